// ==== include/lcd_ps_pkg.sv ====
// Shared constants and types for the panel power-save sequencer and its bus host.
// Assumes a 100 MHz system clock on both ends.
package lcd_ps_pkg;

	// Link widths and access spaces
	localparam int        LINK_AW       = 8;
	localparam int        LINK_DW       = 8;
	localparam logic [1:0] SPACE_REG    = 2'h0;
	localparam logic [1:0] SPACE_MEM    = 2'h1;
	localparam logic [1:0] SPACE_LUT    = 2'h2;

	// Device registers on the link
	localparam logic [7:0] MODE_REG_ADDR = 8'h03;
	localparam logic [7:0] GPIO_REG_ADDR = 8'h04;
	localparam logic [7:0] STAT_REG_ADDR = 8'h05;
	localparam logic [1:0] PS_SOFT       = 2'h0;
	localparam logic [1:0] PS_NORMAL     = 2'h3;
	localparam logic [1:0] PS_RESET      = 2'h0;
	localparam logic [7:0] GPIO_RESET    = 8'h00;

	// Power sequencing in frames
	localparam int SEQ_FRAMES  = 127;
	localparam int STOP_FRAMES = 128;

	// Timing
	localparam int CLK_PERIOD_NS  = 10;
	localparam int BUS_PERIOD_NS  = 80;
	localparam int MCLK_PERIOD_NS = 40;
	localparam int BUS_HALF_CYC   = (BUS_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
	localparam int MCLK_HALF_CYC  = (MCLK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
	localparam int TAIL_BUS       = 8;
	localparam int TAIL_MCLK      = 12;
	localparam int TAIL_CYC       = (TAIL_BUS * BUS_PERIOD_NS + TAIL_MCLK * MCLK_PERIOD_NS + CLK_PERIOD_NS - 1)
	                                / CLK_PERIOD_NS;
	localparam int WAKE_CYC       = (BUS_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MCLK_IDLE_CYC  = 4 * MCLK_HALF_CYC;

	// Host APB map
	localparam logic [31:0] CMD_OFF      = 32'h0000_0000;
	localparam logic [31:0] STAT_OFF     = 32'h0000_0004;
	localparam logic [31:0] CTRL_OFF     = 32'h0000_0008;
	localparam int          CMD_ADDR_LSB = 8;
	localparam int          CMD_SPACE_LSB = 16;
	localparam int          CMD_WRITE_BIT = 18;
	localparam int          STAT_BUSY_BIT = 0;
	localparam int          STAT_STOP_BIT = 1;
	localparam int          STAT_SOFT_BIT = 2;
	localparam int          STAT_RDATA_LSB = 8;
	localparam int          CTRL_HWPS_BIT = 0;
	localparam int          CTRL_MCLK_BIT = 1;
	localparam logic [1:0]  CTRL_RESET    = 2'h2;

	typedef enum logic [1:0] {SEQ_OFF, SEQ_UP, SEQ_ON, SEQ_DOWN} seq_state_t;
	typedef enum logic [1:0] {MODE_NORMAL, MODE_SOFT, MODE_HARD} ps_mode_t;
	typedef enum logic [2:0] {H_IDLE, H_WAKE, H_WAIT, H_RELEASE} host_state_t;

endpackage

// ==== include/lcd_ps_link.sv ====
// Link between the bus host and the panel power-save device.
// The host makes the bus clock and the input clock; the device samples both.
`timescale 1ns/10ps
`default_nettype none
interface lcd_ps_link;
	logic       busClk;
	logic       busSel;
	logic       busWrite;
	logic [1:0] busSpace;
	logic [7:0] busAddr;
	logic [7:0] busWdata;
	logic [7:0] busRdata;
	logic       busReady;
	logic       hwPowerSave;
	logic       inputClock;
	logic       clocksMayStop;

	modport device (
		input  busClk, busSel, busWrite, busSpace, busAddr, busWdata, hwPowerSave, inputClock,
		output busRdata, busReady, clocksMayStop
	);
	modport host (
		output busClk, busSel, busWrite, busSpace, busAddr, busWdata, hwPowerSave, inputClock,
		input  busRdata, busReady, clocksMayStop
	);
endinterface
`default_nettype wire

// ==== core/lcd_power_save_sequencer.sv ====
// Panel power-save device: mode select, access gating, panel power sequencing.
// Assumes link inputs come from another clock domain and are synchronised here.
//
// Behaviour
// - Mode from hardware pin and two bits
// - Soft save: panel off, fetch and timing halted
// - Soft save keeps registers, memory; table blocked
// - Hardware save: bus interface fully disabled
// - Power save forces panel outputs low
// - GPIO output pins keep their state
// - After reset panel power off, outputs low
// - Writing normal bits starts power-up
// - 127 frames between power and signals
// - Host writes table only in normal
// - Soft save entry/exit runs down/up sequence
// - Host may stop bus clock glitch-free
// - Bus clock runs 8 bus+12 input periods
// - Bus clock restarts one period before access; code counts WAKE_CYC high cycles, so access comes 2.5 periods after restart
// - Memory access needs input clock running
// - Soft save: input clock stops after 128
// - Hardware save: input clock stops after 128
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module lcd_power_save_sequencer
	import lcd_ps_pkg::*;
#(
	parameter int MEM_DEPTH    = 256,
	parameter int FRAME_CYCLES = 1024,
	parameter int LINE_CYCLES  = 64
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// Bus link
	lcd_ps_link.device       link,
	// Configuration strap
	input  wire logic        hwPsConfigured,
	// Panel
	output logic             panel_power_enable,
	output logic [11:0]      panel_pixel_bus,
	output logic             panel_shift_clock,
	output logic             panel_line_pulse,
	output logic             panel_frame_pulse,
	output logic             panel_data_valid
);

	localparam int SYNC_W = 24;
	localparam int MW     = $clog2(MEM_DEPTH);
	localparam int FW     = $clog2(FRAME_CYCLES);
	localparam int LW     = $clog2(LINE_CYCLES);

	// Input synchroniser
	logic [SYNC_W-1:0] syncMeta;
	logic [SYNC_W-1:0] syncOut;
	wire  [SYNC_W-1:0] syncIn = {link.busClk, link.busSel, link.busWrite, link.busSpace, link.busAddr,
	                             link.busWdata, link.hwPowerSave, hwPsConfigured, link.inputClock};

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			syncMeta <= '0;
			syncOut  <= '0;
		end else begin
			syncMeta <= syncIn;
			syncOut  <= syncMeta;
		end
	end

	wire       busClkS  = syncOut[23];
	wire       selS     = syncOut[22];
	wire       writeS   = syncOut[21];
	wire [1:0] spaceS   = syncOut[20:19];
	wire [7:0] addrS    = syncOut[18:11];
	wire [7:0] wdataS   = syncOut[10:3];
	wire       hwPinS   = syncOut[2];
	wire       hwCfgS   = syncOut[1];
	wire       mclkS    = syncOut[0];

	// State
	logic        busClkPrev;
	logic        mclkPrev;
	logic [7:0]  mclkIdle;
	logic [1:0]  psBits;
	logic [3:0]  gpioOut;
	logic [3:0]  gpioOe;
	logic        ready;
	logic [7:0]  rdata;
	logic [3:0]  lut [16];
	logic [7:0]  mem [MEM_DEPTH];
	logic [FW-1:0] frameCnt;
	logic [LW-1:0] lineCnt;
	logic [6:0]  seqCnt;
	logic [7:0]  psFrames;
	logic [MW-1:0] fetchAddr;
	seq_state_t  seqState;
	seq_state_t  next_seqState;

	// Mode select
	wire       hardPs = hwCfgS & hwPinS;
	ps_mode_t  mode;
	assign mode = hardPs ? MODE_HARD : ((psBits == PS_NORMAL) ? MODE_NORMAL : MODE_SOFT);
	wire       wantOn = (mode == MODE_NORMAL);

	// Access decode
	wire busRise   = busClkS & ~busClkPrev;
	wire mclkAlive = (mclkIdle < 8'(MCLK_IDLE_CYC));
	wire memOk     = (spaceS != SPACE_MEM) | mclkAlive;
	wire access    = busRise & selS & ~ready & ~hardPs & memOk;
	wire doWrite   = access & writeS;
	wire regSpace  = (spaceS == SPACE_REG);
	wire modeWr    = doWrite & regSpace & (addrS == MODE_REG_ADDR);
	wire gpioWr    = doWrite & regSpace & (addrS == GPIO_REG_ADDR);
	wire memWr     = doWrite & (spaceS == SPACE_MEM);
	wire lutOpen   = wantOn;
	wire lutWr     = doWrite & (spaceS == SPACE_LUT) & lutOpen;
	wire [MW-1:0] memIdx = MW'(addrS);

	logic [7:0] readMux;
	wire  [7:0] statWord = {3'h0, link.clocksMayStop, hardPs, 1'b0, seqState};
	assign readMux = (spaceS == SPACE_MEM) ? mem[memIdx] :
	                 (spaceS == SPACE_LUT) ? (lutOpen ? {4'h0, lut[addrS[3:0]]} : 8'h00) :
	                 (addrS == MODE_REG_ADDR) ? {6'h00, psBits} :
	                 (addrS == GPIO_REG_ADDR) ? {gpioOe, gpioOut} :
	                 (addrS == STAT_REG_ADDR) ? statWord : 8'h00;

	// Link answer
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			busClkPrev <= 1'b0;
			ready      <= 1'b0;
			rdata      <= 8'h00;
		end else begin
			busClkPrev <= busClkS;
			if (access) begin
				ready <= 1'b1;
				rdata <= readMux;
			end else if (!selS) begin
				ready <= 1'b0;
			end
		end
	end
	assign link.busReady = ready;
	assign link.busRdata = rdata;

	// Input clock activity
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mclkPrev <= 1'b0;
			mclkIdle <= 8'(MCLK_IDLE_CYC);
		end else begin
			mclkPrev <= mclkS;
			if (mclkS != mclkPrev)
				mclkIdle <= 8'h00;
			else if (mclkAlive)
				mclkIdle <= mclkIdle + 8'h01;
		end
	end

	// Registers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			psBits  <= PS_RESET;
			gpioOut <= GPIO_RESET[3:0];
			gpioOe  <= GPIO_RESET[7:4];
		end else begin
			if (modeWr)
				psBits <= wdataS[1:0];
			if (gpioWr) begin
				gpioOut <= wdataS[3:0];
				gpioOe  <= wdataS[7:4];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (memWr)
			mem[memIdx] <= wdataS;
		if (lutWr)
			lut[addrS[3:0]] <= wdataS[3:0];
	end

	// Frame ticks for sequence timing
	wire frameTick = (frameCnt == FW'(FRAME_CYCLES - 1));
	wire seqLast   = frameTick & (seqCnt == 7'(SEQ_FRAMES - 1));

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			frameCnt <= '0;
			psFrames <= 8'h00;
		end else begin
			frameCnt <= frameTick ? '0 : frameCnt + FW'(1);
			if (wantOn)
				psFrames <= 8'h00;
			else if (frameTick && psFrames != 8'(STOP_FRAMES))
				psFrames <= psFrames + 8'h01;
		end
	end

	// Power sequencer
	always_comb begin
		next_seqState = seqState;
		case (seqState)
			SEQ_OFF:  if (wantOn) next_seqState = SEQ_UP;
			SEQ_UP:   if (!wantOn) next_seqState = SEQ_OFF;
			          else if (seqLast) next_seqState = SEQ_ON;
			SEQ_ON:   if (!wantOn) next_seqState = SEQ_DOWN;
			SEQ_DOWN: if (seqLast) next_seqState = SEQ_OFF;
			default:  next_seqState = SEQ_OFF;
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			seqState <= SEQ_OFF;
			seqCnt   <= 7'h00;
		end else begin
			seqState <= next_seqState;
			if (next_seqState != seqState)
				seqCnt <= 7'h00;
			else if (frameTick)
				seqCnt <= seqCnt + 7'h01;
		end
	end

	assign link.clocksMayStop = (seqState == SEQ_OFF) && (psFrames == 8'(STOP_FRAMES));

	// Display timing and refresh, running only when on
	wire        active   = (seqState == SEQ_ON);
	wire        lineEnd  = (lineCnt == LW'(LINE_CYCLES - 1));
	wire [7:0]  pixByte  = mem[fetchAddr];
	wire [3:0]  pixHigh  = lut[pixByte[3:0]];
	logic [3:0] gpioPins;
	assign gpioPins = (gpioOe & gpioOut) | (~gpioOe & (active ? pixHigh : 4'h0));

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			lineCnt            <= '0;
			fetchAddr          <= '0;
			panel_power_enable <= 1'b0;
			panel_pixel_bus    <= 12'h000;
			panel_shift_clock  <= 1'b0;
			panel_line_pulse   <= 1'b0;
			panel_frame_pulse  <= 1'b0;
			panel_data_valid   <= 1'b0;
		end else begin
			lineCnt            <= (active && !lineEnd) ? lineCnt + LW'(1) : '0;
			fetchAddr          <= active ? fetchAddr + MW'(1) : '0;
			panel_power_enable <= (seqState != SEQ_OFF);
			panel_pixel_bus    <= {gpioPins, active ? pixByte : 8'h00};
			panel_shift_clock  <= active & ~panel_shift_clock;
			panel_line_pulse   <= active & lineEnd;
			panel_frame_pulse  <= active & frameTick;
			panel_data_valid   <= active & ~lineEnd;
		end
	end

endmodule
`default_nettype wire

// ==== core/lcd_bus_host.sv ====
// Bus host: APB slave for software, drives the link, gates bus and input clocks.
// Assumes the device answers on the link asynchronously to this clock.
`timescale 1ns/10ps
`default_nettype none
module lcd_bus_host
	import lcd_ps_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// APB
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Link
	lcd_ps_link.host         link
);

	// Answer synchroniser
	logic [9:0] syncMeta;
	logic [9:0] syncOut;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			syncMeta <= '0;
			syncOut  <= '0;
		end else begin
			syncMeta <= {link.busReady, link.clocksMayStop, link.busRdata};
			syncOut  <= syncMeta;
		end
	end
	wire       readyS    = syncOut[9];
	wire       mayStopS  = syncOut[8];
	wire [7:0] rdataS    = syncOut[7:0];

	// APB decode
	wire apbSetup = psel & ~penable;
	wire apbWr    = psel & penable & pwrite;
	wire hitCmd   = (paddr == CMD_OFF);
	wire hitStat  = (paddr == STAT_OFF);
	wire hitCtrl  = (paddr == CTRL_OFF);
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~(hitCmd | hitStat | hitCtrl);

	logic [18:0] cmd;
	logic [1:0]  ctrl;
	logic [7:0]  result;
	logic        busy;
	logic        softPs;
	host_state_t hState;
	logic [7:0]  wakeCnt;
	logic [7:0]  tailCnt;
	logic [7:0]  busDiv;
	logic [7:0]  mclkDiv;
	logic        busClk;
	logic        mclk;

	wire [31:0] statWord = {16'h0000, result, 5'h00, softPs, mayStopS, busy};
	wire [31:0] readMux  = hitCmd ? {13'h0000, cmd} : hitStat ? statWord : hitCtrl ? {30'h0, ctrl} : 32'h0;
	wire        launch   = apbWr & hitCmd & ~busy;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			prdata <= 32'h0;
			cmd    <= 19'h0;
			ctrl   <= CTRL_RESET;
		end else begin
			if (apbSetup)
				prdata <= readMux;
			if (launch)
				cmd <= pwdata[18:0];
			if (apbWr && hitCtrl)
				ctrl <= pwdata[1:0];
		end
	end

	// Clock dividers, stopped only while low
	wire busTerm  = (busDiv == 8'(BUS_HALF_CYC - 1));
	wire busFall  = busTerm & busClk;
	wire busRun   = (hState != H_IDLE) | (tailCnt != 8'h00) | softPs;
	wire mclkTerm = (mclkDiv == 8'(MCLK_HALF_CYC - 1));
	wire mclkRun  = ctrl[CTRL_MCLK_BIT] | ~mayStopS;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			busDiv  <= 8'h00;
			busClk  <= 1'b0;
			mclkDiv <= 8'h00;
			mclk    <= 1'b0;
		end else begin
			busDiv  <= busTerm ? 8'h00 : busDiv + 8'h01;
			if (busTerm && (busRun || busClk))
				busClk <= ~busClk;
			mclkDiv <= mclkTerm ? 8'h00 : mclkDiv + 8'h01;
			if (mclkTerm && (mclkRun || mclk))
				mclk <= ~mclk;
		end
	end

	// Access sequencer, link signals change only on falling bus clock
	wire wakeDone = (wakeCnt >= 8'(WAKE_CYC));
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hState         <= H_IDLE;
			busy           <= 1'b0;
			softPs         <= 1'b1;
			wakeCnt        <= 8'h00;
			tailCnt        <= 8'h00;
			result         <= 8'h00;
			link.busSel    <= 1'b0;
			link.busWrite  <= 1'b0;
			link.busSpace  <= SPACE_REG;
			link.busAddr   <= 8'h00;
			link.busWdata  <= 8'h00;
		end else begin
			if (tailCnt != 8'h00)
				tailCnt <= tailCnt - 8'h01;
			case (hState)
				H_IDLE: if (launch) begin
					busy    <= 1'b1;
					wakeCnt <= 8'h00;
					hState  <= H_WAKE;
				end
				H_WAKE: begin
					if (busClk && !wakeDone)
						wakeCnt <= wakeCnt + 8'h01;
					if (wakeDone && busFall) begin
						link.busSel   <= 1'b1;
						link.busWrite <= cmd[CMD_WRITE_BIT];
						link.busSpace <= cmd[CMD_SPACE_LSB +: 2];
						link.busAddr  <= cmd[CMD_ADDR_LSB +: 8];
						link.busWdata <= cmd[7:0];
						hState        <= H_WAIT;
					end
				end
				H_WAIT: if (readyS && busFall) begin
					link.busSel <= 1'b0;
					result      <= rdataS;
					tailCnt     <= 8'(TAIL_CYC);
					if (link.busWrite && link.busSpace == SPACE_REG && link.busAddr == MODE_REG_ADDR)
						softPs <= (link.busWdata[1:0] != PS_NORMAL);
					hState      <= H_RELEASE;
				end
				H_RELEASE: if (!readyS) begin
					busy   <= 1'b0;
					hState <= H_IDLE;
				end
				default: hState <= H_IDLE;
			endcase
		end
	end

	assign link.busClk      = busClk;
	assign link.inputClock  = mclk;
	assign link.hwPowerSave = ctrl[CTRL_HWPS_BIT];

endmodule
`default_nettype wire

// ==== tb/lcd_ps_checker.sv ====
// Concurrent checks on the link and the panel outputs of the sequencer.
// Assumes FRAME_CYCLES matches the value given to the sequencer.
`timescale 1ns/10ps
`default_nettype none
module lcd_ps_checker
	import lcd_ps_pkg::*;
#(
	parameter int FRAME_CYCLES = 1024
) (
	// Clock and reset
	input wire logic        clk,
	input wire logic        reset,
	// Link
	input wire logic        busSel,
	input wire logic        busReady,
	input wire logic        hwPowerSave,
	input wire logic        clocksMayStop,
	// Device pins
	input wire logic        hwPsConfigured,
	input wire logic        panel_power_enable,
	input wire logic [11:0] panel_pixel_bus,
	input wire logic        panel_shift_clock,
	input wire logic        panel_line_pulse,
	input wire logic        panel_frame_pulse,
	input wire logic        panel_data_valid
);
	localparam int LOW  = 126 * FRAME_CYCLES;
	localparam int HIGH = 128 * FRAME_CYCLES + 8;
	int   onCnt;
	int   idleCnt;
	logic shiftSeen;
	wire  hardSave = hwPowerSave & hwPsConfigured;
	wire  anyOut   = panel_shift_clock | panel_line_pulse | panel_frame_pulse | panel_data_valid;

	// Cycles with power on, cycles since the shift clock was last high
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			onCnt     <= 0;
			idleCnt   <= 0;
			shiftSeen <= 1'b0;
		end else begin
			onCnt     <= panel_power_enable ? onCnt + 1 : 0;
			idleCnt   <= panel_shift_clock ? 0 : idleCnt + 1;
			shiftSeen <= panel_power_enable & (shiftSeen | panel_shift_clock);
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	off_outputs_low_a: assert property (!panel_power_enable |-> !anyOut && panel_pixel_bus[7:0] == 8'h00)
		else $error("panel output active with power off");
	up_delay_min_a: assert property (panel_shift_clock |-> onCnt >= LOW)
		else $error("display started too soon after power on");
	up_delay_max_a: assert property (panel_power_enable && !shiftSeen |-> onCnt <= HIGH)
		else $error("display did not start after power on");
	down_delay_min_a: assert property ($fell(panel_power_enable) && $past(shiftSeen) |-> $past(idleCnt) >= LOW)
		else $error("power dropped too soon after display stop");
	down_delay_max_a: assert property (panel_power_enable && shiftSeen |-> idleCnt <= HIGH)
		else $error("power held too long after display stop");
	hard_save_quiet_a: assert property (hardSave [*8] |-> !anyOut && !$rose(busReady))
		else $error("activity during hardware power save");
	ready_cause_a: assert property ($rose(busReady) |-> $past(busSel, 3) && !$past(hardSave, 3))
		else $error("answer without a request");
	ready_hold_a: assert property (busReady && busSel |=> busReady)
		else $error("answer dropped while request held");
	stop_after_off_a: assert property (clocksMayStop |-> !panel_power_enable && !anyOut)
		else $error("clock stop allowed with panel live");
	shift_toggle_a: assert property (panel_shift_clock |=> !panel_shift_clock)
		else $error("shift clock stuck high");
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Bench joining the bus host and the sequencer over the link, driven over APB.
// Assumes short frame and line counts so each power sequence ends quickly.
`timescale 1ns/10ps
`default_nettype none
module tb
	import lcd_ps_pkg::*;
;
	localparam int FR = 16;
	typedef struct {logic [1:0] sp; logic [7:0] a; logic [7:0] d; logic [7:0] x; logic wr;} row_t;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic        hwPsConfigured = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        panel_power_enable;
	logic [11:0] panel_pixel_bus;
	logic        panel_shift_clock;
	logic        panel_line_pulse;
	logic        panel_frame_pulse;
	logic        panel_data_valid;
	logic [31:0] r;
	logic        e;
	logic [7:0]  b;
	int          n_fail = 0;
	int          comparisons = 0;
	int          cyc = 0;
	int          t0;
	row_t        rows[5] = '{
		'{SPACE_REG, GPIO_REG_ADDR, 8'hF5, 8'hF5, 1'b1},
		'{SPACE_MEM, 8'h10, 8'hA5, 8'hA5, 1'b1},
		'{SPACE_MEM, 8'hFF, 8'h5A, 8'h5A, 1'b1},
		'{SPACE_LUT, 8'h02, 8'h3C, 8'h00, 1'b1},
		'{SPACE_REG, MODE_REG_ADDR, 8'h00, {6'h0, PS_RESET}, 1'b0}};

	lcd_ps_link lcd_ps_link_inst ();
	lcd_power_save_sequencer #(.FRAME_CYCLES(FR), .LINE_CYCLES(4)) lcd_power_save_sequencer_inst (.clk, .reset,
		.link(lcd_ps_link_inst.device), .hwPsConfigured, .panel_power_enable, .panel_pixel_bus,
		.panel_shift_clock, .panel_line_pulse, .panel_frame_pulse, .panel_data_valid);
	lcd_bus_host lcd_bus_host_inst (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .link(lcd_ps_link_inst.host));
	lcd_ps_checker #(.FRAME_CYCLES(FR)) lcd_ps_checker_inst (.clk, .reset, .busSel(lcd_ps_link_inst.busSel),
		.busReady(lcd_ps_link_inst.busReady), .hwPowerSave(lcd_ps_link_inst.hwPowerSave),
		.clocksMayStop(lcd_ps_link_inst.clocksMayStop), .hwPsConfigured, .panel_power_enable, .panel_pixel_bus,
		.panel_shift_clock, .panel_line_pulse, .panel_frame_pulse, .panel_data_valid);

	always #5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task timeout(input string what);
		n_fail++;
		$display("wrong value at %0t: %s timed out", $time, what);
		give_verdict;
	endtask

	// One APB transfer; read data and error taken at the accepting edge
	task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (k == 20) timeout("apb");
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task issue(input logic [1:0] sp, input logic [7:0] a, input logic wr, input logic [7:0] d);
		apb(1'b1, CMD_OFF, {13'h0, wr, sp, a, d});
	endtask

	// Poll until the link access is done, keep its read byte
	task finish;
		int k;
		for (k = 0; k < 400; k++) begin
			apb(1'b0, STAT_OFF, 32'h0);
			if (r[STAT_BUSY_BIT] === 1'b0) break;
		end
		if (k == 400) timeout("link access");
		b = r[STAT_RDATA_LSB +: 8];
	endtask

	task acc(input logic [1:0] sp, input logic [7:0] a, input logic wr, input logic [7:0] d);
		issue(sp, a, wr, d);
		finish;
	endtask

	task waitLvl(input int sel, input logic lvl, input int lim);
		int   k;
		logic v;
		for (k = 0; k < lim; k++) begin
			@(negedge clk);
			v = sel == 0 ? panel_power_enable : sel == 1 ? panel_shift_clock : lcd_ps_link_inst.clocksMayStop;
			if (v === lvl) break;
		end
		if (k == lim) timeout("level wait");
	endtask

	initial begin
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		check({panel_pixel_bus, panel_shift_clock, panel_line_pulse, panel_frame_pulse, panel_data_valid,
			panel_power_enable}, 32'h0, "panel after reset");
		apb(1'b0, 32'h0000_000C, 32'h0);
		check(e, 32'h1, "unmapped error");
		check(r, 32'h0, "unmapped data");
		$display("reset test done");
		foreach (rows[i]) begin
			if (rows[i].wr) acc(rows[i].sp, rows[i].a, 1'b1, rows[i].d);
			acc(rows[i].sp, rows[i].a, 1'b0, 8'h00);
			check(b, rows[i].x, "link read");
		end
		check(panel_pixel_bus, 32'h500, "gpio pins");
		$display("soft save access test done");
		for (int m = 0; m < 3; m++) begin
			acc(SPACE_REG, MODE_REG_ADDR, 1'b1, 8'(m));
			repeat (3 * FR) @(posedge clk);
			check(panel_power_enable, 32'h0, "power in save mode");
		end
		$display("mode select test done");
		t0 = cyc;
		acc(SPACE_REG, MODE_REG_ADDR, 1'b1, {6'h0, PS_NORMAL});
		check({panel_power_enable, panel_shift_clock}, 32'h2, "power before display");
		waitLvl(1, 1'b1, 130 * FR);
		check(cyc - t0 >= 126 * FR, 32'h1, "power up delay");
		acc(SPACE_LUT, 8'h02, 1'b1, 8'h3C);
		acc(SPACE_LUT, 8'h02, 1'b0, 8'h00);
		check(b, 32'h0C, "table in normal");
		$display("power up test done");
		t0 = cyc;
		acc(SPACE_REG, MODE_REG_ADDR, 1'b1, {6'h0, PS_SOFT});
		check({panel_shift_clock, panel_data_valid, panel_power_enable}, 32'h1, "display stop");
		waitLvl(0, 1'b0, 130 * FR);
		check(cyc - t0 >= 126 * FR, 32'h1, "power down delay");
		waitLvl(2, 1'b1, 4 * FR + 100);
		repeat (2) @(posedge clk);
		apb(1'b0, STAT_OFF, 32'h0);
		check(r[STAT_STOP_BIT], 32'h1, "clock stop flag");
		$display("power down test done");
		apb(1'b1, CTRL_OFF, 32'h0);
		repeat (20) @(posedge clk);
		issue(SPACE_MEM, 8'h10, 1'b0, 8'h00);
		repeat (300) @(posedge clk);
		apb(1'b0, STAT_OFF, 32'h0);
		check(r[STAT_BUSY_BIT], 32'h1, "memory with input clock stopped");
		apb(1'b1, CTRL_OFF, 32'h2);
		finish;
		check(b, 32'hA5, "memory after input clock restart");
		$display("input clock test done");
		for (int c = 0; c < 2; c++) begin
			hwPsConfigured <= c[0];
			apb(1'b1, CTRL_OFF, 32'h3);
			issue(SPACE_REG, MODE_REG_ADDR, 1'b0, 8'h00);
			repeat (300) @(posedge clk);
			apb(1'b0, STAT_OFF, 32'h0);
			check(r[STAT_BUSY_BIT], c, "hardware save busy");
			apb(1'b1, CTRL_OFF, 32'h2);
			finish;
			check(b, {30'h0, PS_SOFT}, "mode read after release");
		end
		$display("hardware save test done");
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		check({panel_pixel_bus, panel_power_enable, lcd_ps_link_inst.busReady}, 32'h0, "panel after mid-run reset");
		acc(SPACE_REG, GPIO_REG_ADDR, 1'b0, 8'h00);
		check(b, GPIO_RESET, "gpio after mid-run reset");
		$display("mid-run reset test done");
		give_verdict;
	end
endmodule
`default_nettype wire
